// ===== hw/ipc_pkg.sv
// Package: register map, field layouts and timing constants of the configuration slice
package ipc_pkg;
   // ----------------------------------------------------------------------
   // ----------------------------------------------------------------------

   // ----------------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ----------------------------------------------------------------------
   localparam logic [9:0] IPC_IDX_FWD = 10'h017;
   localparam logic [9:0] IPC_IDX_HIGH = 10'h018;
   localparam logic [9:0] IPC_IDX_LOW = 10'h019;
   localparam logic [9:0] IPC_IDX_PATH = 10'h01a;

   // Reset values
   localparam logic [7:0] IPC_FWD_RST = 8'h1e;
   localparam logic [7:0] IPC_SCL_RST = 8'h7f;
   localparam logic [7:0] IPC_PATH_RST = 8'h01;

   // Field positions
   localparam int IPC_FWD_PASS_BIT = 7;
   localparam int IPC_PATH_AUX_BIT = 3;
   localparam int IPC_PATH_WIDE_BIT = 1;
   localparam int IPC_PATH_SURR_BIT = 0;

   // ----------------------------------------------------------------------
   // Timing; one clock cycle stands for one oscillator period
   // ----------------------------------------------------------------------
   localparam int IPC_CLK_PERIOD_NS = 40;
   localparam int IPC_HOLD_STEP_NS = 40;
   localparam int IPC_FILT_STEP_NS = 5;
   localparam int IPC_SCL_EXTRA = 5;

   // Forwarding control fields
   typedef struct packed {
      logic pass_all;
      logic [2:0] hold;
      logic [3:0] filt;
   } ipc_fwd_ctrl_t;

   // Payload path controls that software owns
   typedef struct packed {
      logic wide_word_mode;
      logic surround;
   } ipc_path_ctrl_t;

   // Filter depth to cycles, rounded up; a wider reject window is the safe side
   function automatic logic [2:0] ipc_filt_cycles(input logic [3:0] depth);
      int ns;
      ns = int'(depth) * IPC_FILT_STEP_NS;
      return 3'((ns + IPC_CLK_PERIOD_NS - 1) / IPC_CLK_PERIOD_NS);
   endfunction : ipc_filt_cycles

   // Hold steps to cycles
   function automatic logic [2:0] ipc_hold_cycles(input logic [2:0] hold);
      return 3'((int'(hold) * IPC_HOLD_STEP_NS) / IPC_CLK_PERIOD_NS);
   endfunction : ipc_hold_cycles
endpackage : ipc_pkg

// ===== hw/ipc_glitch_filter.sv
// Glitch filter: a new level is taken only once it has stood past the limit
`timescale 1ns/1ps
module ipc_glitch_filter #(
   parameter int CW = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic raw,
   input wire logic [CW-1:0] limit,
   output logic clean
);
   logic [CW-1:0] cnt;

   // Pulses of limit cycles or fewer never reach clean
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clean <= 1'b1;
         cnt <= '0;
      end else if (raw == clean) begin
         cnt <= '0;
      end else if (cnt >= limit) begin
         clean <= raw;
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end
endmodule : ipc_glitch_filter

// ===== hw/ipc_cfg.sv
// Forwarding, master timing and payload path configuration with an APB slave
`timescale 1ns/1ps
module ipc_cfg
   import ipc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic second_port_select,
   input wire logic [6:0] own_target_id,
   input wire logic [6:0] remote_deser_id,
   input wire logic [6:0] remote_target_id,
   input wire logic access_valid,
   input wire logic [6:0] access_target_id,
   output logic forward_port0,
   output logic forward_port1,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_filtered,
   output logic sda_sampled,
   input wire logic master_enable,
   output logic scl_out_oe,
   input wire logic target_stretch_req,
   input wire logic target_data_ready,
   output logic target_scl_oe,
   input wire logic aux_audio_strap,
   input wire logic repeater_mode,
   input wire logic inband_surround_detect,
   input wire logic data_island_transport,
   output logic wide_word_mode,
   output logic surround_audio_en
);
   typedef enum logic [1:0] {MS_IDLE, MS_HIGH, MS_LOW} ipc_ms_t;
   typedef enum logic [1:0] {TS_IDLE, TS_WAIT, TS_SETUP} ipc_ts_t;

   ipc_fwd_ctrl_t fwd;
   logic pass_all_p1;
   logic [7:0] clk_high;
   logic [7:0] clk_low;
   ipc_path_ctrl_t path;
   logic aux_audio;
   logic strap_taken;
   logic [7:0] sda_pipe;
   logic sda_filt;
   ipc_ms_t ms_state, next_ms;
   logic [8:0] ms_cnt, next_ms_cnt;
   ipc_ts_t ts_state, next_ts;
   logic [8:0] ts_cnt, next_ts_cnt;

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   wire [9:0] word_idx = paddr[11:2];
   wire hit_fwd = (word_idx == IPC_IDX_FWD);
   wire hit_high = (word_idx == IPC_IDX_HIGH);
   wire hit_low = (word_idx == IPC_IDX_LOW);
   wire hit_path = (word_idx == IPC_IDX_PATH);
   wire hit_any = hit_fwd | hit_high | hit_low | hit_path;
   wire access_ph = psel & penable & !pready;
   wire commit = psel & penable & pready;
   wire wr_ok = commit & pwrite & !pslverr;
   wire pass_view = second_port_select ? pass_all_p1 : fwd.pass_all;
   wire [7:0] path_view = {4'h0, aux_audio, 1'b0, path};
   wire [7:0] rd_byte = hit_fwd ? {pass_view, fwd.hold, fwd.filt} :
                        hit_high ? clk_high :
                        hit_low ? clk_low :
                        hit_path ? path_view : 8'h00;

   // One wait state per transfer; unmapped words answer with pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access_ph;
         pslverr <= access_ph & !hit_any;
         prdata <= (access_ph & !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   // Writes land only at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd <= IPC_FWD_RST;
         pass_all_p1 <= IPC_FWD_RST[IPC_FWD_PASS_BIT];
         clk_high <= IPC_SCL_RST;
         clk_low <= IPC_SCL_RST;
         path <= {IPC_PATH_RST[IPC_PATH_WIDE_BIT], IPC_PATH_RST[IPC_PATH_SURR_BIT]};
      end else if (wr_ok) begin
         if (hit_fwd) begin
            fwd.hold <= pwdata[6:4];
            fwd.filt <= pwdata[3:0];
            if (second_port_select) begin
               pass_all_p1 <= pwdata[IPC_FWD_PASS_BIT];
            end else begin
               fwd.pass_all <= pwdata[IPC_FWD_PASS_BIT];
            end
         end
         if (hit_high) begin
            clk_high <= pwdata[7:0];
         end
         if (hit_low) begin
            clk_low <= pwdata[7:0];
         end
         if (hit_path) begin
            path <= {pwdata[IPC_PATH_WIDE_BIT], pwdata[IPC_PATH_SURR_BIT]};
         end
      end
   end

   // Strap caught once after release; a reset cannot sample a pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_audio <= 1'b0;
         strap_taken <= 1'b0;
      end else if (!strap_taken) begin
         aux_audio <= aux_audio_strap;
         strap_taken <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Forwarding decision
   // ----------------------------------------------------------------------
   function automatic logic fwd_decide(input logic pass, input logic [6:0] id);
      if (pass) begin
         return id != own_target_id;
      end
      return (id == remote_deser_id) || (id == remote_target_id);
   endfunction : fwd_decide

   wire next_fwd0 = access_valid & fwd_decide(fwd.pass_all, access_target_id);
   wire next_fwd1 = access_valid & fwd_decide(pass_all_p1, access_target_id);

   // One pulse per forwarded access, per port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         forward_port0 <= 1'b0;
         forward_port1 <= 1'b0;
      end else begin
         forward_port0 <= next_fwd0;
         forward_port1 <= next_fwd1;
      end
   end

   // ----------------------------------------------------------------------
   // Input conditioning
   // ----------------------------------------------------------------------
   wire [2:0] filt_cyc = ipc_filt_cycles(fwd.filt);
   wire [2:0] hold_cyc = ipc_hold_cycles(fwd.hold);

   ipc_glitch_filter #(.CW(3)) u_scl_filt (
      .pclk(pclk),
      .presetn(presetn),
      .raw(scl_in),
      .limit(filt_cyc),
      .clean(scl_filtered)
   );

   ipc_glitch_filter #(.CW(3)) u_sda_filt (
      .pclk(pclk),
      .presetn(presetn),
      .raw(sda_in),
      .limit(filt_cyc),
      .clean(sda_filt)
   );

   // SDA delay line; resolution is one clock, 40 ns
   wire sda_tap = (hold_cyc == 3'd0) ? sda_filt : sda_pipe[hold_cyc - 3'd1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_pipe <= 8'hff;
         sda_sampled <= 1'b1;
      end else begin
         sda_pipe <= {sda_pipe[6:0], sda_filt};
         sda_sampled <= sda_tap;
      end
   end

   // ----------------------------------------------------------------------
   // Local master SCL generator
   // ----------------------------------------------------------------------
   wire [8:0] high_load = 9'(clk_high) + 9'(IPC_SCL_EXTRA - 1);
   wire [8:0] low_load = 9'(clk_low) + 9'(IPC_SCL_EXTRA - 1);

   // High phase pauses while another device holds SCL low
   always_comb begin
      next_ms = ms_state;
      next_ms_cnt = ms_cnt;
      unique case (ms_state)
         MS_IDLE: begin
            if (master_enable) begin
               next_ms = MS_HIGH;
               next_ms_cnt = high_load;
            end
         end
         MS_HIGH: begin
            if (scl_filtered) begin
               if (ms_cnt == 9'd0) begin
                  next_ms = MS_LOW;
                  next_ms_cnt = low_load;
               end else begin
                  next_ms_cnt = ms_cnt - 9'd1;
               end
            end
         end
         MS_LOW: begin
            if (ms_cnt == 9'd0) begin
               next_ms = master_enable ? MS_HIGH : MS_IDLE;
               next_ms_cnt = high_load;
            end else begin
               next_ms_cnt = ms_cnt - 9'd1;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_state <= MS_IDLE;
         ms_cnt <= 9'd0;
         scl_out_oe <= 1'b0;
      end else begin
         ms_state <= next_ms;
         ms_cnt <= next_ms_cnt;
         scl_out_oe <= (next_ms == MS_LOW);
      end
   end

   // ----------------------------------------------------------------------
   // Target-side clock stretch over the control channel
   // ----------------------------------------------------------------------
   always_comb begin
      next_ts = ts_state;
      next_ts_cnt = ts_cnt;
      unique case (ts_state)
         TS_IDLE: begin
            if (target_stretch_req) begin
               next_ts = TS_WAIT;
            end
         end
         TS_WAIT: begin
            if (target_data_ready) begin
               next_ts = TS_SETUP;
               next_ts_cnt = low_load;
            end
         end
         TS_SETUP: begin
            if (ts_cnt == 9'd0) begin
               next_ts = TS_IDLE;
            end else begin
               next_ts_cnt = ts_cnt - 9'd1;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ts_state <= TS_IDLE;
         ts_cnt <= 9'd0;
         target_scl_oe <= 1'b0;
      end else begin
         ts_state <= next_ts;
         ts_cnt <= next_ts_cnt;
         target_scl_oe <= (next_ts != TS_IDLE);
      end
   end

   // ----------------------------------------------------------------------
   // Payload path outputs
   // ----------------------------------------------------------------------
   // Repeater detection outranks software; non-island transport cannot carry it
   wire surround_pick = repeater_mode ? inband_surround_detect : path.surround;
   wire next_surround = data_island_transport & surround_pick;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wide_word_mode <= 1'b0;
         surround_audio_en <= 1'b0;
      end else begin
         wide_word_mode <= path.wide_word_mode;
         surround_audio_en <= next_surround;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   logic [8:0] hi_len, lo_len, su_len;

   // Phase length counters seen only by the checks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_len <= 9'd0;
         lo_len <= 9'd0;
         su_len <= 9'd0;
      end else begin
         hi_len <= (ms_state == MS_HIGH) ? hi_len + 9'(scl_filtered) : 9'd0;
         lo_len <= (ms_state == MS_LOW) ? lo_len + 9'd1 : 9'd0;
         su_len <= (ts_state == TS_SETUP) ? su_len + 9'd1 : 9'd0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_hi_end;
      ms_state == MS_HIGH ##1 ms_state == MS_LOW;
   endsequence

   chk_match_forward: assert property (
      access_valid && !fwd.pass_all |=> forward_port0 ==
         ($past(access_target_id) == remote_deser_id || $past(access_target_id) == remote_target_id))
      else $error("port0 forward ignores ID match");
   chk_pass_all: assert property (
      access_valid && pass_all_p1 |=> forward_port1 == ($past(access_target_id) != own_target_id))
      else $error("port1 pass-all forward wrong");
   chk_port_steer: assert property (
      wr_ok && hit_fwd && second_port_select |=> $stable(fwd.pass_all) &&
         pass_all_p1 == $past(pwdata[IPC_FWD_PASS_BIT]))
      else $error("pass-all write went to wrong port");
   chk_sda_delay: assert property (
      fwd.hold == 3'd3 && $past(fwd.hold, 4) == 3'd3 |-> sda_sampled == $past(sda_filt, 4))
      else $error("SDA hold delay wrong");
   chk_high_len: assert property (
      s_hi_end |-> $past(hi_len) == 9'(clk_high) + 9'(IPC_SCL_EXTRA - 1))
      else $error("SCL high phase length wrong");
   chk_low_len: assert property (
      ms_state == MS_LOW && next_ms != MS_LOW |-> lo_len + 9'd1 == 9'(clk_low) + 9'(IPC_SCL_EXTRA))
      else $error("SCL low phase length wrong");
   chk_setup_len: assert property (
      ts_state == TS_SETUP ##1 ts_state == TS_IDLE |->
         $past(su_len) + 9'd1 == 9'(clk_low) + 9'(IPC_SCL_EXTRA))
      else $error("target setup interval wrong");
   chk_oe_phase: assert property (
      ms_state == MS_LOW |-> scl_out_oe)
      else $error("SCL not driven in low phase");
   chk_path_read: assert property (
      commit && !pwrite && hit_path |-> prdata[7:4] == 4'h0 && !prdata[2] &&
         prdata[IPC_PATH_AUX_BIT] == aux_audio)
      else $error("payload path readback wrong");
   chk_word_mode: assert property (
      wr_ok && hit_path |=> ##1 wide_word_mode == $past(pwdata[IPC_PATH_WIDE_BIT], 2))
      else $error("word mode not applied");
   chk_surround_island: assert property (
      surround_audio_en |-> $past(data_island_transport))
      else $error("surround without data island");
   chk_repeater_over: assert property (
      repeater_mode && data_island_transport |=> surround_audio_en == $past(inband_surround_detect))
      else $error("repeater override ignored");
endmodule : ipc_cfg

// ===== dv/ipc_i2c_bus.sv
// Local I2C bus model: open-drain SCL and SDA wires with pull-ups
`timescale 1ns/1ps
module ipc_i2c_bus (
   input wire logic scl_out_oe,
   input wire logic target_scl_oe,
   input wire logic peer_scl_low,
   input wire logic peer_sda_low,
   output logic scl_in,
   output logic sda_in
);
   // Wired-AND; a released wire goes to the pull-up level, never holds a stale value
   assign scl_in = !(scl_out_oe || target_scl_oe || peer_scl_low);
   assign sda_in = !peer_sda_low;
endmodule : ipc_i2c_bus

// ===== dv/tb_top.sv
// Self-checking testbench for the configuration slice
`timescale 1ns/1ps
module tb_top;
   import ipc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic port_sel = 1'b0, acc_valid = 1'b0, master_en = 1'b0;
   logic [6:0] acc_id = 7'h00;
   logic fwd0, fwd1, scl_in, sda_in, scl_filt, sda_samp, scl_oe, tgt_oe;
   logic stretch_req = 1'b0, data_rdy = 1'b0, strap = 1'b1;
   logic rep = 1'b0, inband = 1'b0, island = 1'b0, wide, surr;
   logic peer_scl_low = 1'b0, peer_sda_low = 1'b0;
   int error_cnt = 0;
   int n_compared = 0;

   always #20 pclk = ~pclk;

   ipc_cfg dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .second_port_select(port_sel), .own_target_id(7'h10),
      .remote_deser_id(7'h20), .remote_target_id(7'h30), .access_valid(acc_valid),
      .access_target_id(acc_id), .forward_port0(fwd0), .forward_port1(fwd1),
      .scl_in(scl_in), .sda_in(sda_in), .scl_filtered(scl_filt), .sda_sampled(sda_samp),
      .master_enable(master_en), .scl_out_oe(scl_oe), .target_stretch_req(stretch_req),
      .target_data_ready(data_rdy), .target_scl_oe(tgt_oe), .aux_audio_strap(strap),
      .repeater_mode(rep), .inband_surround_detect(inband),
      .data_island_transport(island), .wide_word_mode(wide), .surround_audio_en(surr));

   ipc_i2c_bus bus (.scl_out_oe(scl_oe), .target_scl_oe(tgt_oe),
      .peer_scl_low(peer_scl_low), .peer_sda_low(peer_sda_low), .scl_in(scl_in),
      .sda_in(sda_in));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // APB transfer; request held until pready is seen high at a rising edge
   // No wait count assumed here; only the watchdog ends a stuck transfer
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, {idx, 2'b00}, {24'h00_0000, d}, rd, err);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0000_0000, rd, err);
      check("prdata", rd, exp);
      check("pslverr", {31'h0, err}, {31'h0, exp_err});
   endtask : rd_chk

   task automatic cycles(input int n);
      repeat (n) @(posedge pclk);
   endtask : cycles

   task finish_test;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_regs;
      rd_chk({IPC_IDX_FWD, 2'b00}, 32'h0000_001e, 1'b0);
      rd_chk({IPC_IDX_HIGH, 2'b00}, 32'h0000_007f, 1'b0);
      rd_chk({IPC_IDX_LOW, 2'b00}, 32'h0000_007f, 1'b0);
      rd_chk({IPC_IDX_PATH, 2'b00}, 32'h0000_0009, 1'b0);
      rd_chk(12'h06c, 32'h0000_0000, 1'b1);
      wr(IPC_IDX_PATH, 8'hf6);
      rd_chk({IPC_IDX_PATH, 2'b00}, 32'h0000_000a, 1'b0);
      @(negedge pclk);
      check("wide_word_mode", {31'h0, wide}, 32'h0000_0001);
   endtask : t_regs

   task automatic fwd(input logic [6:0] id, input logic e0, input logic e1);
      @(posedge pclk);
      acc_valid <= 1'b1;
      acc_id <= id;
      @(posedge pclk);
      acc_valid <= 1'b0;
      @(negedge pclk);
      check("forward_port0", {31'h0, fwd0}, {31'h0, e0});
      check("forward_port1", {31'h0, fwd1}, {31'h0, e1});
   endtask : fwd

   task automatic t_forward;
      fwd(7'h20, 1'b1, 1'b1);
      fwd(7'h30, 1'b1, 1'b1);
      fwd(7'h40, 1'b0, 1'b0);
      wr(IPC_IDX_FWD, 8'h9e);
      fwd(7'h40, 1'b1, 1'b0);
      fwd(7'h10, 1'b0, 1'b0);
      @(posedge pclk);
      port_sel <= 1'b1;
      rd_chk({IPC_IDX_FWD, 2'b00}, 32'h0000_001e, 1'b0);
      // Pass-all on for the second port only, then off for the first
      wr(IPC_IDX_FWD, 8'h9e);
      port_sel <= 1'b0;
      wr(IPC_IDX_FWD, 8'h1e);
      fwd(7'h40, 1'b0, 1'b1);
      rd_chk({IPC_IDX_FWD, 2'b00}, 32'h0000_001e, 1'b0);
      port_sel <= 1'b1;
      rd_chk({IPC_IDX_FWD, 2'b00}, 32'h0000_009e, 1'b0);
      port_sel <= 1'b0;
   endtask : t_forward

   // Phase lengths counted at mid-cycle while the output holds its level
   task automatic span(input logic lvl, output int n);
      int g;
      n = 0;
      g = 0;
      while (scl_oe !== lvl && g < 600) begin
         @(negedge pclk);
         g++;
      end
      while (scl_oe === lvl && n < 600) begin
         @(negedge pclk);
         n++;
      end
   endtask : span

   task automatic t_master;
      int n;
      wr(IPC_IDX_HIGH, 8'h02);
      wr(IPC_IDX_LOW, 8'h03);
      master_en <= 1'b1;
      span(1'b1, n);
      check("scl low span", n, 32'd8);
      check("scl_filtered in low", {31'h0, scl_filt}, 32'h0000_0000);
      // High count pauses for filter latency: depth 14 is 2 cycles, plus one
      span(1'b0, n);
      check("scl high span", n, 32'd10);
      @(posedge pclk);
      master_en <= 1'b0;
      cycles(20);
      @(posedge pclk);
      stretch_req <= 1'b1;
      @(posedge pclk);
      stretch_req <= 1'b0;
      @(negedge pclk);
      check("target_scl_oe", {31'h0, tgt_oe}, 32'h0000_0001);
      cycles(4);
      data_rdy <= 1'b1;
      @(posedge pclk);
      data_rdy <= 1'b0;
      n = 0;
      @(negedge pclk);
      while (tgt_oe === 1'b1 && n < 600) begin
         n++;
         @(negedge pclk);
      end
      check("stretch tail", n, 32'd8);
   endtask : t_master

   task automatic sda_delay(input logic [7:0] cfg, output int d);
      wr(IPC_IDX_FWD, cfg);
      cycles(10);
      peer_sda_low <= 1'b1;
      d = 0;
      do begin
         @(negedge pclk);
         d++;
      end while (sda_samp !== 1'b0 && d < 50);
      @(posedge pclk);
      peer_sda_low <= 1'b0;
   endtask : sda_delay

   task automatic t_sda;
      int d0, d3;
      sda_delay(8'h00, d0);
      sda_delay(8'h30, d3);
      check("hold delay", d3 - d0, 32'd3);
      wr(IPC_IDX_FWD, 8'h08);
      cycles(10);
      // One-cycle pulse on both wires; depth 8 rejects one 40 ns cycle
      peer_sda_low <= 1'b1;
      peer_scl_low <= 1'b1;
      @(posedge pclk);
      peer_sda_low <= 1'b0;
      peer_scl_low <= 1'b0;
      repeat (8) begin
         @(negedge pclk);
         check("glitch rejected", {31'h0, sda_samp}, 32'h0000_0001);
         check("scl glitch rejected", {31'h0, scl_filt}, 32'h0000_0001);
      end
   endtask : t_sda

   task automatic t_surround;
      logic [3:0] tbl [4] = '{4'b1001, 4'b1100, 4'b1111, 4'b0000};
      wr(IPC_IDX_PATH, 8'h01);
      foreach (tbl[i]) begin
         @(posedge pclk);
         island <= tbl[i][3];
         rep <= tbl[i][2];
         inband <= tbl[i][1];
         cycles(2);
         @(negedge pclk);
         check("surround_audio_en", {31'h0, surr}, {31'h0, tbl[i][0]});
      end
      check("wide_word_mode off", {31'h0, wide}, 32'h0000_0000);
   endtask : t_surround

   // ----------------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------------
   initial begin
      cycles(3);
      presetn <= 1'b1;
      cycles(2);
      t_regs();
      t_forward();
      t_master();
      t_sda();
      t_surround();
      finish_test();
   end

   // Scenarios take a few hundred cycles; this span leaves wide margin
   initial begin
      cycles(20000);
      error_cnt++;
      finish_test();
   end
endmodule : tb_top
